//--- dv/rearm_trigger_timestamp_test.sv
// Self-checking bench for the re-arm trigger and timestamp block.
`timescale 1ns/1ps
`include "rtt_map.vh"
module rearm_trigger_timestamp_test;
  logic        clk = 0;
  logic        rst = 1;
  logic        wr = 0;
  logic        rd = 0;
  logic [15:0] addr = 0;
  logic [31:0] wdata = 0;
  logic        start = 0;
  logic        stop = 0;
  logic        go = 0;
  logic [15:0] lvl = 0;
  logic        rdy = 0;
  wire         sv;
  wire  [15:0] sd;
  wire  [31:0] rdata;
  wire         ack, gate, trig, armed, lost, tv;
  wire  [63:0] td;
  int          fail_count = 0;
  int          n_compared = 0;
  int          i;
  logic [63:0] n_smp = 0;
  logic [63:0] q[$];
  // Rows: sample, then expected {armed, gate, trigger}; positive rows first.
  localparam logic [18:0] ROWS [15] = '{{16'h0000, 3'b000}, {16'h003C, 3'b100},
    {16'h0078, 3'b011}, {16'h005A, 3'b010}, {16'h006E, 3'b010}, {16'h0028, 3'b000},
    {16'h003C, 3'b100}, {16'h0078, 3'b011}, {16'h00C8, 3'b000}, {16'h005A, 3'b100},
    {16'h0028, 3'b011}, {16'h003C, 3'b010}, {16'h0028, 3'b010}, {16'h006E, 3'b000},
    {16'h005A, 3'b100}};
  rtt_top i_dut (.i_sys_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_card_start(start), .i_card_stop(stop), .i_smp_valid(sv), .i_smp_data(sd),
    .o_gate(gate), .o_trig_pulse(trig), .o_armed(armed), .o_stamp_lost(lost),
    .o_stamp_valid(tv), .o_stamp_data(td), .i_stamp_ready(rdy));
  rtt_smp_src i_src (.i_sys_clk(clk), .i_go(go), .i_level(lvl), .o_smp_valid(sv),
    .o_smp_data(sd));
  always #10 clk = ~clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(string nm, logic [63:0] e, logic [63:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task wreg(logic [15:0] a, logic [31:0] d);
    @(posedge clk);
    #1 wr = 1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 0;
    chk("write ack", 1, ack);
  endtask
  task rreg(logic [15:0] a, logic [31:0] e);
    @(posedge clk);
    #1 rd = 1;
    addr = a;
    @(posedge clk);
    #1 rd = 0;
    chk("read ack", 1, ack);
    chk("rdata", e, rdata);
  endtask
  task automatic strobe(ref logic s);
    @(posedge clk);
    #1 s = 1;
    @(posedge clk);
    #1 s = 0;
  endtask
  // The engine answers in the cycle right after the sample cycle.
  task smp(logic [15:0] v, logic [2:0] e);
    @(posedge clk);
    #1 go = 1;
    lvl = v;
    @(posedge clk);
    #1 go = 0;
    @(posedge clk);
    #1 chk("engine", e, {armed, gate, trig});
    if (e[0] && q.size() < 17)
      q.push_back(n_smp);
    n_smp++;
  endtask
  task drain;
    int w;
    while (q.size() > 0)
    begin
      for (w = 0; w < 8 && tv !== 1'b1; w++)
        @(posedge clk) #1;
      chk("stamp valid", 1, tv);
      chk("stamp", q.pop_front(), td);
      rdy = 1;
      @(posedge clk);
      #1 rdy = 0;
      @(posedge clk);
      #1;
    end
  endtask
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    fail_count++;
    stop_test;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    rreg(`RTT_OFS_TRIG_MODE, `RTT_RST_TRIG_MODE);
    rreg(`RTT_OFS_REARM_THR, `RTT_RST_THR);
    rreg(`RTT_OFS_STAMP_CMD, `RTT_RST_STAMP_MODE);
    rreg(16'h1234, 32'h0);
    chk("gate", 0, gate);
    wreg(`RTT_OFS_TRIG_MODE, `RTT_MODE_REARM_POS);
    rreg(`RTT_OFS_TRIG_MODE, `RTT_MODE_REARM_POS);
    wreg(`RTT_OFS_TRIG_THR, 32'h64);
    rreg(`RTT_OFS_TRIG_THR, 32'h64);
    wreg(`RTT_OFS_REARM_THR, 32'h32);
    // An unmapped write must leave the levels alone.
    wreg(16'h1234, 32'hFFFFFFFF);
    rreg(`RTT_OFS_REARM_THR, 32'h32);
    wreg(`RTT_OFS_STAMP_CMD, `RTT_STAMP_RESET_CMD);
    strobe(start);
    for (i = 0; i < 15; i++)
    begin
      // Rows from 8 on run in negative mode with the levels swapped.
      if (i == 8)
      begin
        wreg(`RTT_OFS_TRIG_MODE, `RTT_MODE_REARM_NEG);
        wreg(`RTT_OFS_TRIG_THR, 32'h32);
        wreg(`RTT_OFS_REARM_THR, 32'h64);
      end
      smp(ROWS[i][18:3], ROWS[i][2:0]);
    end
    // Overfill the stamp FIFO while the drain side stalls.
    wreg(`RTT_OFS_TRIG_MODE, `RTT_MODE_REARM_POS);
    wreg(`RTT_OFS_TRIG_THR, 32'h64);
    wreg(`RTT_OFS_REARM_THR, 32'h32);
    smp(16'h0000, 3'b000);
    repeat (15)
    begin
      smp(16'h003C, 3'b100);
      smp(16'h0078, 3'b011);
      smp(16'h0028, 3'b000);
    end
    chk("lost", 1, lost);
    drain;
    repeat (2) @(posedge clk) #1;
    chk("stamp valid", 0, tv);
    wreg(`RTT_OFS_STAMP_CMD, `RTT_STAMP_START_RESET_MODE);
    rreg(`RTT_OFS_STAMP_CMD, `RTT_STAMP_START_RESET_MODE);
    strobe(stop);
    smp(16'h003C, 3'b000);
    strobe(start);
    n_smp = 0;
    chk("lost", 0, lost);
    smp(16'h0000, 3'b000);
    smp(16'h003C, 3'b100);
    smp(16'h0078, 3'b011);
    drain;
    // A reset command outside standard mode leaves the count running.
    wreg(`RTT_OFS_STAMP_CMD, `RTT_STAMP_RESET_CMD);
    smp(16'h0028, 3'b000);
    smp(16'h003C, 3'b100);
    smp(16'h0078, 3'b011);
    drain;
    // In standard mode the explicit command clears a running count.
    wreg(`RTT_OFS_STAMP_CMD, `RTT_STAMP_MANUAL_RESET_MODE);
    wreg(`RTT_OFS_STAMP_CMD, `RTT_STAMP_RESET_CMD);
    n_smp = 0;
    smp(16'h0028, 3'b000);
    smp(16'h003C, 3'b100);
    smp(16'h0078, 3'b011);
    drain;
    // With stamps disabled the trigger still fires but nothing is queued.
    wreg(`RTT_OFS_STAMP_CMD, `RTT_STAMP_DISABLE);
    rreg(`RTT_OFS_STAMP_CMD, `RTT_STAMP_DISABLE);
    smp(16'h0028, 3'b000);
    smp(16'h003C, 3'b100);
    smp(16'h0078, 3'b011);
    q.delete();
    repeat (4) @(posedge clk) #1;
    chk("stamp valid", 0, tv);
    // The rising-select flag alone is no re-arm mode: the gate stays shut.
    wreg(`RTT_OFS_TRIG_MODE, `RTT_RISING_SELECT_FLAG);
    smp(16'h0028, 3'b000);
    smp(16'h003C, 3'b000);
    smp(16'h0078, 3'b000);
    @(posedge clk);
    #1 rst = 1;
    repeat (2) @(posedge clk);
    #1 chk("reset outputs", 0, {gate, armed, tv});
    rst = 0;
    rreg(`RTT_OFS_TRIG_MODE, `RTT_RST_TRIG_MODE);
    rreg(`RTT_OFS_STAMP_CMD, `RTT_RST_STAMP_MODE);
    stop_test;
  end
endmodule // rearm_trigger_timestamp_test

//--- dv/rtt_monitor.sv
// Concurrent checks on the ports of the trigger and timestamp block.
`timescale 1ns/1ps
`include "rtt_map.vh"
module rtt_monitor #(
  parameter STAMP_W = 64
) (
  // Clock and reset
  input wire               i_sys_clk,
  input wire               i_rst,
  // Register port
  input wire               i_reg_wr,
  input wire               i_reg_rd,
  input wire [15:0]        i_reg_addr,
  input wire               o_reg_ack,
  // Samples and trigger outputs
  input wire               i_smp_valid,
  input wire               o_gate,
  input wire               o_trig_pulse,
  input wire               o_armed,
  // Timestamp stream
  input wire               o_stamp_valid,
  input wire [STAMP_W-1:0] o_stamp_data,
  input wire               i_stamp_ready
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  ack_after_req_a: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack)
    else $error("register request not acknowledged");
  fire_needs_arm_a: assert property (o_trig_pulse |-> $past(o_armed))
    else $error("trigger fired while disarmed");
  fire_opens_a: assert property (o_trig_pulse |-> o_gate && !o_armed)
    else $error("trigger did not open gate and disarm");
  trig_single_a: assert property (o_trig_pulse |=> !o_trig_pulse)
    else $error("trigger fired twice in a row");
  gate_rise_a: assert property ($rose(o_gate) |-> o_trig_pulse)
    else $error("gate opened without trigger");
  arm_rise_a: assert property ($rose(o_armed) |-> $past(i_smp_valid))
    else $error("engine armed without a sample");
  mode_disarm_a: assert property ((i_reg_wr && i_reg_addr == `RTT_OFS_TRIG_MODE)
    |=> !o_armed && !o_gate)
    else $error("mode write left engine armed or gate open");
  reset_clear_a: assert property ($fell(i_rst) |-> !o_gate && !o_armed && !o_stamp_valid)
    else $error("outputs not cleared by reset");
  stamp_hold_a: assert property (o_stamp_valid && !i_stamp_ready
    |=> o_stamp_valid && $stable(o_stamp_data))
    else $error("stamp changed while stalled");
  cover property (o_trig_pulse);
  cover property ($fell(o_gate));
  cover property (o_stamp_valid && i_stamp_ready);
endmodule // rtt_monitor
bind rtt_top rtt_monitor #(.STAMP_W(STAMP_W)) i_mon (.*);

//--- dv/rtt_smp_src.sv
// Sample source standing in for the digitized analog channel.
`timescale 1ns/1ps
module rtt_smp_src (
  // Clock
  input  wire        i_sys_clk,
  // Control from the bench
  input  wire        i_go,
  input  wire [15:0] i_level,
  // Sample stream
  output reg         o_smp_valid,
  output reg  [15:0] o_smp_data
);
  initial
  begin
    o_smp_valid = 1'b0;
    o_smp_data  = 16'h0000;
  end
  // Idle cycles show the inverse of the previous cycle's data, so a stale value never passes.
  always @(posedge i_sys_clk)
  begin
    o_smp_valid <= i_go;
    o_smp_data  <= i_go ? i_level : ~o_smp_data;
  end
endmodule // rtt_smp_src

//--- hw/rtt_fifo.v
// Timestamp FIFO with a registered output stage and valid/ready on both sides.
`timescale 1ns/1ps
module rtt_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             i_sys_clk,
  input  wire             i_rst,
  // Filling side
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output reg              o_in_ready,
  // Draining side
  output reg              o_out_valid,
  output reg  [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);

  reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_q;
  reg  [AW-1:0]    rd_ptr_q;
  reg  [AW:0]      count_q;
  wire             push;
  wire             pop;

  // The output register refills from a non-empty store whenever it is empty or being taken.
  assign push = i_in_valid && o_in_ready;
  assign pop  = (count_q != {(AW+1){1'b0}}) && (!o_out_valid || i_out_ready);

  always @(posedge i_sys_clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= i_in_data;
  end

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      wr_ptr_q    <= {AW{1'b0}};
      rd_ptr_q    <= {AW{1'b0}};
      count_q     <= {(AW+1){1'b0}};
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
      o_out_data  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
      begin
        rd_ptr_q   <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        o_out_data <= mem_q[rd_ptr_q];
      end
      if (pop)
        o_out_valid <= 1'b1;
      else if (i_out_ready)
        o_out_valid <= 1'b0;
      if (push && !pop)
      begin
        count_q    <= count_q + {{AW{1'b0}}, 1'b1};
        o_in_ready <= (count_q + {{AW{1'b0}}, 1'b1}) < DEPTH;
      end
      else if (pop && !push)
      begin
        count_q    <= count_q - {{AW{1'b0}}, 1'b1};
        o_in_ready <= 1'b1;
      end
    end
  end

endmodule // rtt_fifo

//--- hw/rtt_map.vh
// Register map, field values and reset values of the re-arm trigger and timestamp block.
`ifndef RTT_MAP_VH
`define RTT_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RTT_OFS_TRIG_MODE   16'h9EA2
`define RTT_OFS_TRIG_THR    16'hA4D8
`define RTT_OFS_REARM_THR   16'hA53C
`define RTT_OFS_STAMP_CMD   16'hB798

// ----------------------------------------------------------------------------
// Trigger mode flags and combined values
// ----------------------------------------------------------------------------
`define RTT_RISING_SELECT_FLAG      32'h00000001
`define RTT_FALLING_SELECT_FLAG     32'h00000002
`define RTT_REARM_ENABLE_FLAG       32'h01000000
`define RTT_HYSTERESIS_ENABLE_FLAG  32'h20000000
`define RTT_MODE_REARM_POS          32'h21000001
`define RTT_MODE_REARM_NEG          32'h21000002

// ----------------------------------------------------------------------------
// Timestamp command values
// ----------------------------------------------------------------------------
`define RTT_STAMP_DISABLE           32'h00000000
`define RTT_STAMP_RESET_CMD         32'h00000001
`define RTT_STAMP_MANUAL_RESET_MODE 32'h00000002
`define RTT_STAMP_START_RESET_MODE  32'h00000004
`define RTT_STAMP_MODE_MASK         32'h00000006

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RTT_RST_TRIG_MODE   32'h00000000
`define RTT_RST_THR         32'h00000000
`define RTT_RST_STAMP_MODE  32'h00000002

`endif

//--- hw/rtt_top.v
// Re-arm hysteresis trigger engine with gate output and sample-count timestamp capture.
`timescale 1ns/1ps
`include "rtt_map.vh"
module rtt_top #(
  parameter SMP_W   = 16,
  parameter STAMP_W = 64,
  parameter DEPTH   = 16,
  parameter AW      = 4
) (
  // Clock and reset
  input  wire               i_sys_clk,
  input  wire               i_rst,
  // Register port
  input  wire               i_reg_wr,
  input  wire               i_reg_rd,
  input  wire [15:0]        i_reg_addr,
  input  wire [31:0]        i_reg_wdata,
  output reg  [31:0]        o_reg_rdata,
  output reg                o_reg_ack,
  // Acquisition control
  input  wire               i_card_start,
  input  wire               i_card_stop,
  // Sample stream
  input  wire               i_smp_valid,
  input  wire [SMP_W-1:0]   i_smp_data,
  // Trigger outputs
  output reg                o_gate,
  output reg                o_trig_pulse,
  output reg                o_armed,
  output reg                o_stamp_lost,
  // Timestamp stream
  output wire               o_stamp_valid,
  output wire [STAMP_W-1:0] o_stamp_data,
  input  wire               i_stamp_ready
);

  // --------------------------------------------------------------------------
  // Engine states
  // --------------------------------------------------------------------------
  localparam [1:0] ST_DISARMED = 2'b01;
  localparam [1:0] ST_ARMED    = 2'b10;

  reg  [31:0]        trig_mode_q;
  reg  [31:0]        trig_thr_q;
  reg  [31:0]        rearm_thr_q;
  reg  [31:0]        stamp_mode_q;
  reg  [1:0]         state_q;
  reg  [1:0]         state_d;
  reg                gate_d;
  reg                fire_d;
  reg                running_q;
  reg                have_prev_q;
  reg  [SMP_W-1:0]   prev_q;
  reg  [STAMP_W-1:0] stamp_cnt_q;
  wire               wr_mode;
  wire               wr_cmd;
  wire               mode_pos;
  wire               mode_neg;
  wire               sample_ok;
  wire               trg_up;
  wire               trg_dn;
  wire               arm_up;
  wire               arm_dn;
  wire               cmd_reset;
  wire               start_reset;
  wire               stamp_en;
  wire               fifo_ready;
  wire [31:0]        cmd_mode_field;

  // --------------------------------------------------------------------------
  // Crossing detection
  // --------------------------------------------------------------------------
  // A crossing needs the previous sample below (or at and above) the level
  // and the current sample on the other side; the level is taken signed.
  function cross_up;
    input [SMP_W-1:0] prev;
    input [SMP_W-1:0] cur;
    input [SMP_W-1:0] lvl;
    begin
      cross_up = ($signed(prev) < $signed(lvl)) && ($signed(cur) >= $signed(lvl));
    end
  endfunction

  function cross_dn;
    input [SMP_W-1:0] prev;
    input [SMP_W-1:0] cur;
    input [SMP_W-1:0] lvl;
    begin
      cross_dn = ($signed(prev) >= $signed(lvl)) && ($signed(cur) < $signed(lvl));
    end
  endfunction

  assign mode_pos  = (trig_mode_q == `RTT_MODE_REARM_POS);
  assign mode_neg  = (trig_mode_q == `RTT_MODE_REARM_NEG);
  assign sample_ok = i_smp_valid && have_prev_q && running_q;
  // Levels come from software-written registers, low bits only.
  assign trg_up = sample_ok && cross_up(prev_q, i_smp_data, trig_thr_q[SMP_W-1:0]);
  assign trg_dn = sample_ok && cross_dn(prev_q, i_smp_data, trig_thr_q[SMP_W-1:0]);
  assign arm_up = sample_ok && cross_up(prev_q, i_smp_data, rearm_thr_q[SMP_W-1:0]);
  assign arm_dn = sample_ok && cross_dn(prev_q, i_smp_data, rearm_thr_q[SMP_W-1:0]);

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  assign wr_mode = i_reg_wr && (i_reg_addr == `RTT_OFS_TRIG_MODE);
  assign wr_cmd  = i_reg_wr && (i_reg_addr == `RTT_OFS_STAMP_CMD);
  assign cmd_mode_field = i_reg_wdata & `RTT_STAMP_MODE_MASK;

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      trig_mode_q  <= `RTT_RST_TRIG_MODE;
      trig_thr_q   <= `RTT_RST_THR;
      rearm_thr_q  <= `RTT_RST_THR;
      stamp_mode_q <= `RTT_RST_STAMP_MODE;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        `RTT_OFS_TRIG_MODE: trig_mode_q <= i_reg_wdata;
        `RTT_OFS_TRIG_THR:  trig_thr_q  <= i_reg_wdata;
        `RTT_OFS_REARM_THR: rearm_thr_q <= i_reg_wdata;
        `RTT_OFS_STAMP_CMD:
        begin
          // A pure reset command leaves the mode alone.
          if (cmd_mode_field != 32'h00000000)
            stamp_mode_q <= cmd_mode_field;
          else if (i_reg_wdata == `RTT_STAMP_DISABLE)
            stamp_mode_q <= `RTT_STAMP_DISABLE;
        end
        default: ;
      endcase
    end
  end

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_reg_rdata <= 32'h00000000;
      o_reg_ack   <= 1'b0;
    end
    else
    begin
      o_reg_ack <= i_reg_wr || i_reg_rd;
      if (i_reg_rd)
      begin
        case (i_reg_addr)
          `RTT_OFS_TRIG_MODE: o_reg_rdata <= trig_mode_q;
          `RTT_OFS_TRIG_THR:  o_reg_rdata <= trig_thr_q;
          `RTT_OFS_REARM_THR: o_reg_rdata <= rearm_thr_q;
          `RTT_OFS_STAMP_CMD: o_reg_rdata <= stamp_mode_q;
          default:            o_reg_rdata <= 32'h00000000;
        endcase
      end
      else
        o_reg_rdata <= 32'h00000000;
    end
  end

  // --------------------------------------------------------------------------
  // Acquisition run state and previous sample
  // --------------------------------------------------------------------------
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      running_q   <= 1'b0;
      have_prev_q <= 1'b0;
      prev_q      <= {SMP_W{1'b0}};
    end
    else
    begin
      if (i_card_start)
        running_q <= 1'b1;
      else if (i_card_stop)
        running_q <= 1'b0;
      // Start and mode writes drop the history so that a level already
      // beyond a threshold does not count as a crossing.
      if (i_card_start || wr_mode || !running_q)
        have_prev_q <= 1'b0;
      else if (i_smp_valid)
        have_prev_q <= 1'b1;
      if (i_smp_valid)
        prev_q <= i_smp_data;
    end
  end

  // --------------------------------------------------------------------------
  // Re-arm trigger engine
  // --------------------------------------------------------------------------
  always @*
  begin
    state_d = state_q;
    gate_d  = o_gate;
    fire_d  = 1'b0;
    case (state_q)
      ST_DISARMED:
      begin
        if (mode_pos && arm_up)
          state_d = ST_ARMED;
        else if (mode_neg && arm_dn)
          state_d = ST_ARMED;
        // Trigger crossings are not looked at here.
      end
      ST_ARMED:
      begin
        if (mode_pos && trg_up)
        begin
          fire_d  = 1'b1;
          state_d = ST_DISARMED;
        end
        else if (mode_neg && trg_dn)
        begin
          fire_d  = 1'b1;
          state_d = ST_DISARMED;
        end
      end
      default: state_d = ST_DISARMED;
    endcase
    // Closing is independent of the armed state; a fire in the same
    // sample as a close leaves the gate open.
    if (mode_pos && arm_dn)
      gate_d = 1'b0;
    if (mode_neg && arm_up)
      gate_d = 1'b0;
    if (fire_d)
      gate_d = 1'b1;
    if (!mode_pos && !mode_neg)
    begin
      state_d = ST_DISARMED;
      gate_d  = 1'b0;
    end
  end

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_q      <= ST_DISARMED;
      o_gate       <= 1'b0;
      o_trig_pulse <= 1'b0;
      o_armed      <= 1'b0;
    end
    else if (wr_mode || i_card_start)
    begin
      state_q      <= ST_DISARMED;
      o_gate       <= 1'b0;
      o_trig_pulse <= 1'b0;
      o_armed      <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      o_gate       <= gate_d;
      o_trig_pulse <= fire_d;
      o_armed      <= (state_d == ST_ARMED);
    end
  end

  // --------------------------------------------------------------------------
  // Timestamp counter
  // --------------------------------------------------------------------------
  assign stamp_en    = (stamp_mode_q != `RTT_STAMP_DISABLE);
  assign cmd_reset   = wr_cmd && ((i_reg_wdata & `RTT_STAMP_RESET_CMD) != 32'h00000000)
                       && (stamp_mode_q == `RTT_STAMP_MANUAL_RESET_MODE);
  assign start_reset = i_card_start
                       && (stamp_mode_q == `RTT_STAMP_START_RESET_MODE);

  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      stamp_cnt_q <= {STAMP_W{1'b0}};
    else if (cmd_reset || start_reset)
      stamp_cnt_q <= {STAMP_W{1'b0}};
    else if (i_smp_valid)
      stamp_cnt_q <= stamp_cnt_q + {{(STAMP_W-1){1'b0}}, 1'b1};
  end

  // --------------------------------------------------------------------------
  // Timestamp capture
  // --------------------------------------------------------------------------
  // The stamp taken is the count of samples before the triggering one,
  // raw, whatever acquisition mode the card runs in.
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_stamp_lost <= 1'b0;
    else if (fire_d && stamp_en && !fifo_ready && !wr_mode && !i_card_start)
      o_stamp_lost <= 1'b1;
    else if (i_card_start)
      o_stamp_lost <= 1'b0;
  end

  rtt_fifo #(
    .WIDTH (STAMP_W),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_stamp_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (fire_d && stamp_en && !wr_mode && !i_card_start),
    .i_in_data   (stamp_cnt_q),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_stamp_valid),
    .o_out_data  (o_stamp_data),
    .i_out_ready (i_stamp_ready)
  );

endmodule // rtt_top
